// *** ipg_pin_group_ctrl.sv ***
// Pin group controller: two groups of 32 pins, each with its own register set.
// Assumes both register ports run on i_ref_clk and pads are asynchronous.
//
// Overview of operation
// - Groups of up to 32 pins, individually controllable.
// - One write sets, clears or toggles selected pins.
// - Direction bit one means output, zero input.
// - Output pin drives the output level bit.
// - Input value is synchronised, continuously or on demand.
// - Pin level readable in either direction.
// - Input buffer disabled means no sampling.
// - Mux enable routes chosen peripheral function.
// - Selected peripheral drives pad and reads it.
// - Reset leaves pins input with everything disabled.
// - Keeps running in sleep and debug halt.
// - Local bus wins over peripheral bus.
// - Local bus is single-cycle, direction/output/input only.
// - Write protection, bypassed by debugger accesses.
// - Analog function disables digital pad features.
// - Register set repeated per group, rising bases.
// - On-demand sampling lags reads by two cycles.
// - Set, clear, toggle aliases act on ones.
// - Pull direction follows the output level bit.
// - Driving output disables the pull resistor.
//
// Our own choices: the placing of the registers and the plain strobed port.
`default_nettype none
`include "ipg_defs.svh"

module ipg_pin_group_ctrl
  import ipg_pkg::*;
(
  input  wire logic                      i_ref_clk,      // port clock, 250 MHz
  input  wire logic                      i_rst_b,        // asynchronous reset, active low
  input  wire logic [`IPG_AW-1:0]        i_pb_addr,      // peripheral bus byte address
  input  wire logic [31:0]               i_pb_wdata,     // peripheral bus write data
  input  wire logic [3:0]                i_pb_be,        // peripheral bus byte enables
  input  wire logic                      i_pb_wr,        // peripheral bus write strobe
  input  wire logic                      i_pb_rd,        // peripheral bus read strobe
  input  wire logic                      i_pb_debug,     // access comes from the debugger
  output logic [31:0]                    o_pb_rdata,     // peripheral bus read data
  input  wire logic [`IPG_AW-1:0]        i_lb_addr,      // local bus byte address
  input  wire logic [31:0]               i_lb_wdata,     // local bus write data
  input  wire logic [3:0]                i_lb_be,        // local bus byte enables
  input  wire logic                      i_lb_wr,        // local bus write strobe
  input  wire logic                      i_lb_rd,        // local bus read strobe
  output logic [31:0]                    o_lb_rdata,     // local bus read data
  input  wire logic [`IPG_GROUPS-1:0]    i_wr_protect,   // per-group write protection
  input  wire logic [`IPG_ALL_PINS-1:0]  i_pad_in,       // raw pad levels
  output logic [`IPG_ALL_PINS-1:0]       o_pad_out,      // pad output level
  output logic [`IPG_ALL_PINS-1:0]       o_pad_oe,       // pad output driver enable
  output logic [`IPG_ALL_PINS-1:0]       o_pull_en,      // pull resistor enable
  output logic [`IPG_ALL_PINS-1:0]       o_pull_up,      // pull up when high, down when low
  output logic [`IPG_ALL_PINS-1:0]       o_in_buf_en,    // pad input buffer enable
  input  wire logic [`IPG_FUNCS-1:0][`IPG_ALL_PINS-1:0] i_periph_drive, // function levels
  input  wire logic [`IPG_FUNCS-1:0][`IPG_ALL_PINS-1:0] i_periph_oe,    // function enables
  output logic [`IPG_ALL_PINS-1:0]       o_periph_pad_in // synchronised pad level
);
  logic [`IPG_GROUPS-1:0][31:0]                    dir_reg, dir_next;
  logic [`IPG_GROUPS-1:0][31:0]                    out_reg, out_next;
  logic [`IPG_GROUPS-1:0][31:0]                    ctrl_reg, ctrl_next;
  logic [`IPG_GROUPS-1:0][`IPG_PINS-1:0][2:0]      cfg_reg, cfg_next;
  logic [`IPG_GROUPS-1:0][`IPG_PINS-1:0][3:0]      fsel_reg, fsel_next;
  logic [`IPG_GROUPS-1:0][1:0]                     demand_reg, demand_next;
  logic [31:0]                                     pb_rdata_next, lb_rdata_next;
  logic [`IPG_ALL_PINS-1:0]                        out_pad_next, oe_next, pull_en_next;
  logic [`IPG_ALL_PINS-1:0]                        pull_up_next, in_buf_next;
  ipg_dec_type                                     pb_dec, lb_dec;
  logic                                            pb_grp, lb_grp, pb_wen, lb_wen;
  ipg_sync_if                                      sif ();

  // Decodes a group-local offset; misaligned or unmapped offsets hit nothing.
  function automatic ipg_dec_type ipg_decode(input logic [6:0] ofs);
    ipg_dec_type d;
    d.tgt  = IPG_TGT_NONE;
    d.op   = IPG_OP_WRITE;
    d.word = ofs[4:2];
    if (ofs[1:0] == 2'h0)
    begin
      case (ofs)
        `IPG_OFS_DIR:      d.tgt = IPG_TGT_DIR;
        `IPG_OFS_PIN_DIRECTION_CLEAR_A: begin d.tgt = IPG_TGT_DIR; d.op = IPG_OP_CLEAR;  end
        `IPG_OFS_PIN_DIRECTION_SET_A: begin d.tgt = IPG_TGT_DIR; d.op = IPG_OP_SET;    end
        `IPG_OFS_PIN_DIRECTION_TOGGLE_A: begin d.tgt = IPG_TGT_DIR; d.op = IPG_OP_TOGGLE; end
        `IPG_OFS_OUT:      d.tgt = IPG_TGT_OUT;
        `IPG_OFS_OUTPUT_LEVEL_CLEAR_A: begin d.tgt = IPG_TGT_OUT; d.op = IPG_OP_CLEAR;  end
        `IPG_OFS_OUTPUT_LEVEL_SET_A: begin d.tgt = IPG_TGT_OUT; d.op = IPG_OP_SET;    end
        `IPG_OFS_OUTPUT_LEVEL_TOGGLE_A: begin d.tgt = IPG_TGT_OUT; d.op = IPG_OP_TOGGLE; end
        `IPG_OFS_IN:       d.tgt = IPG_TGT_IN;
        `IPG_OFS_CTRL:     d.tgt = IPG_TGT_CTRL;
        default:
        begin
          if (ofs >= `IPG_OFS_PMUX && ofs < `IPG_OFS_PMUX_END)
            d.tgt = IPG_TGT_PMUX;
          else if (ofs >= `IPG_OFS_PINCFG && ofs < `IPG_OFS_PINCFG_END)
            d.tgt = IPG_TGT_PINCFG;
        end
      endcase
    end
    return d;
  endfunction : ipg_decode

  // One write applied to a whole-word register under byte enables.
  function automatic logic [31:0] ipg_apply(input logic [31:0] cur, input logic [31:0] wd,
                                            input logic [3:0] be, input ipg_op_type op);
    logic [31:0] lanes;
    logic [31:0] r;
    for (int b = 0; b < 4; b++)
      lanes[b*8 +: 8] = {8{be[b]}};
    case (op)
      IPG_OP_WRITE:  r = (cur & ~lanes) | (wd & lanes);
      IPG_OP_CLEAR:  r = cur & ~(wd & lanes);
      IPG_OP_SET:    r = cur | (wd & lanes);
      IPG_OP_TOGGLE: r = cur ^ (wd & lanes);
      default:       r = cur;
    endcase
    return r;
  endfunction : ipg_apply

  // Read view of a register; aliases return the register they act on.
  function automatic logic [31:0] ipg_read(input ipg_dec_type d, input logic g);
    logic [31:0] r;
    r = '0;
    case (d.tgt)
      IPG_TGT_DIR:  r = dir_reg[g];
      IPG_TGT_OUT:  r = out_reg[g];
      IPG_TGT_IN:   r = sif.q[g*`IPG_PINS +: `IPG_PINS];
      IPG_TGT_CTRL: r = ctrl_reg[g];
      IPG_TGT_PMUX:
        for (int b = 0; b < 4; b++)
          r[b*8 +: 8] = {fsel_reg[g][d.word[1:0]*8 + b*2 + 1], fsel_reg[g][d.word[1:0]*8 + b*2]};
      IPG_TGT_PINCFG:
        for (int b = 0; b < 4; b++)
          r[b*8 +: 3] = cfg_reg[g][d.word*4 + b];
      default:      r = '0;
    endcase
    return r;
  endfunction : ipg_read

  assign pb_dec = ipg_decode(i_pb_addr[6:0]);
  assign lb_dec = ipg_decode(i_lb_addr[6:0]);
  assign pb_grp = i_pb_addr[`IPG_GRP_BIT];
  assign lb_grp = i_lb_addr[`IPG_GRP_BIT];
  assign pb_wen = i_pb_wr && (!i_wr_protect[pb_grp] || i_pb_debug);
  assign lb_wen = i_lb_wr && !i_wr_protect[lb_grp]
                  && (lb_dec.tgt == IPG_TGT_DIR || lb_dec.tgt == IPG_TGT_OUT);

  // The peripheral write is applied first and the local write on top, so a
  // concurrent local write wins bit by bit without stalling either bus.
  always_comb
  begin
    dir_next    = dir_reg;
    out_next    = out_reg;
    ctrl_next   = ctrl_reg;
    cfg_next    = cfg_reg;
    fsel_next   = fsel_reg;
    demand_next = demand_reg;
    for (int g = 0; g < `IPG_GROUPS; g++)
      if (demand_reg[g] != 2'h0)
        demand_next[g] = demand_reg[g] - 2'h1;
    if (i_pb_rd && pb_dec.tgt == IPG_TGT_IN)
      demand_next[pb_grp] = `IPG_DEMAND_CYCLES;
    if (pb_wen)
    begin
      case (pb_dec.tgt)
        IPG_TGT_DIR:  dir_next[pb_grp] = ipg_apply(dir_reg[pb_grp], i_pb_wdata, i_pb_be,
                                                   pb_dec.op);
        IPG_TGT_OUT:  out_next[pb_grp] = ipg_apply(out_reg[pb_grp], i_pb_wdata, i_pb_be,
                                                   pb_dec.op);
        IPG_TGT_CTRL: ctrl_next[pb_grp] = ipg_apply(ctrl_reg[pb_grp], i_pb_wdata, i_pb_be,
                                                    IPG_OP_WRITE);
        IPG_TGT_PMUX:
          for (int b = 0; b < 4; b++)
            if (i_pb_be[b])
            begin
              fsel_next[pb_grp][pb_dec.word[1:0]*8 + b*2]     = i_pb_wdata[b*8 +: 4];
              fsel_next[pb_grp][pb_dec.word[1:0]*8 + b*2 + 1] = i_pb_wdata[b*8+4 +: 4];
            end
        IPG_TGT_PINCFG:
          for (int b = 0; b < 4; b++)
            if (i_pb_be[b])
              cfg_next[pb_grp][pb_dec.word*4 + b] = i_pb_wdata[b*8 +: 3];
        default: ;
      endcase
    end
    if (lb_wen)
    begin
      if (lb_dec.tgt == IPG_TGT_DIR)
        dir_next[lb_grp] = ipg_apply(dir_next[lb_grp], i_lb_wdata, i_lb_be, lb_dec.op);
      else
        out_next[lb_grp] = ipg_apply(out_next[lb_grp], i_lb_wdata, i_lb_be, lb_dec.op);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      for (int g = 0; g < `IPG_GROUPS; g++)
      begin
        dir_reg[g]    <= `IPG_RST_WORD;
        out_reg[g]    <= `IPG_RST_WORD;
        ctrl_reg[g]   <= `IPG_RST_WORD;
        demand_reg[g] <= 2'h0;
        for (int p = 0; p < `IPG_PINS; p++)
        begin
          cfg_reg[g][p]  <= `IPG_RST_CFG;
          fsel_reg[g][p] <= `IPG_RST_FSEL;
        end
      end
    end
    else
    begin
      dir_reg    <= dir_next;
      out_reg    <= out_next;
      ctrl_reg   <= ctrl_next;
      cfg_reg    <= cfg_next;
      fsel_reg   <= fsel_next;
      demand_reg <= demand_next;
    end
  end

  // Pin path. Nothing here depends on a sleep or debug state, so it runs on.
  for (genvar g = 0; g < `IPG_GROUPS; g++)
  begin : g_grp
    for (genvar p = 0; p < `IPG_PINS; p++)
    begin : g_pin
      localparam int I = g*`IPG_PINS + p;
      logic mux_en, analog, drive;
      assign mux_en = cfg_reg[g][p][`IPG_CFG_PERIPH_MUX_ENABLE];
      assign analog = mux_en && fsel_reg[g][p] == `IPG_FUNC_ANALOG;
      assign drive  = !analog && (mux_en ? i_periph_oe[fsel_reg[g][p]][I]
                                         : dir_reg[g][p]);
      assign oe_next[I]      = drive;
      assign out_pad_next[I] = mux_en ? i_periph_drive[fsel_reg[g][p]][I]
                                      : out_reg[g][p];
      assign pull_en_next[I] = cfg_reg[g][p][`IPG_CFG_PULL_RESISTOR_ENABLE] && !drive
                               && !analog;
      assign pull_up_next[I] = out_reg[g][p];
      assign in_buf_next[I]  = cfg_reg[g][p][`IPG_CFG_INPUT_BUFFER_ENABLE] && !analog;
      // A muxed pin with its input buffer enabled keeps sampling so its peripheral sees the pad level.
      assign sif.en[I] = cfg_reg[g][p][`IPG_CFG_INPUT_BUFFER_ENABLE]
                         && (ctrl_reg[g][p] || demand_reg[g] != 2'h0
                             || mux_en);
    end
  end

  assign sif.pad         = i_pad_in;
  assign o_periph_pad_in = sif.q;

  ipg_pin_sync u_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b),
    .sif       (sif.sync)
  );

  // Local reads are limited to direction, output and input views.
  always_comb
  begin
    pb_rdata_next = i_pb_rd ? ipg_read(pb_dec, pb_grp) : 32'h0000_0000;
    lb_rdata_next = 32'h0000_0000;
    if (i_lb_rd && (lb_dec.tgt == IPG_TGT_DIR || lb_dec.tgt == IPG_TGT_OUT
                    || lb_dec.tgt == IPG_TGT_IN))
      lb_rdata_next = ipg_read(lb_dec, lb_grp);
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_pb_rdata  <= '0;
      o_lb_rdata  <= '0;
      o_pad_out   <= '0;
      o_pad_oe    <= '0;
      o_pull_en   <= '0;
      o_pull_up   <= '0;
      o_in_buf_en <= '0;
    end
    else
    begin
      o_pb_rdata  <= pb_rdata_next;
      o_lb_rdata  <= lb_rdata_next;
      o_pad_out   <= out_pad_next;
      o_pad_oe    <= oe_next;
      o_pull_en   <= pull_en_next;
      o_pull_up   <= pull_up_next;
      o_in_buf_en <= in_buf_next;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);

  logic pb_full0;
  assign pb_full0 = pb_wen && !pb_grp && i_pb_be == 4'hF && !lb_wen;

  AST_PIN_DIRECTION_SET: assert property (
    pb_full0 && pb_dec.tgt == IPG_TGT_DIR && pb_dec.op == IPG_OP_SET
    |=> (dir_reg[0] & $past(i_pb_wdata)) == $past(i_pb_wdata))
    else $error("Direction set alias did not set the written bits.");
  AST_TOGGLE_ATOMIC: assert property (
    pb_full0 && pb_dec.tgt == IPG_TGT_DIR && pb_dec.op == IPG_OP_TOGGLE
    |=> dir_reg[0] == ($past(dir_reg[0]) ^ $past(i_pb_wdata)))
    else $error("Direction toggle changed bits outside the written mask.");
  AST_OUTPUT_LEVEL_CLEAR: assert property (
    pb_full0 && pb_dec.tgt == IPG_TGT_OUT && pb_dec.op == IPG_OP_CLEAR
    |=> (out_reg[0] & $past(i_pb_wdata)) == 32'h0000_0000)
    else $error("Output clear alias left written bits set.");
  AST_LB_PRIORITY: assert property (
    pb_wen && lb_wen && !pb_grp && !lb_grp && pb_dec.tgt == IPG_TGT_OUT
    && lb_dec.tgt == IPG_TGT_OUT && lb_dec.op == IPG_OP_SET && i_lb_be == 4'hF
    |=> (out_reg[0] & $past(i_lb_wdata)) == $past(i_lb_wdata))
    else $error("Local bus write did not win over peripheral bus write.");
  AST_PROTECT: assert property (
    i_pb_wr && i_wr_protect[pb_grp] && !i_pb_debug && !i_lb_wr
    |=> $stable(dir_reg) && $stable(out_reg) && $stable(cfg_reg) && $stable(ctrl_reg))
    else $error("Protected write changed a register.");
  AST_PAD_DIR_LEVEL: assert property (
    !cfg_reg[0][0][`IPG_CFG_PERIPH_MUX_ENABLE]
    |=> o_pad_oe[0] == $past(dir_reg[0][0]) && o_pad_out[0] == $past(out_reg[0][0]))
    else $error("Pad driver does not follow direction and output level.");
  AST_PULL: assert property (
    ##1 (o_pad_oe & o_pull_en) == '0 && (!o_pull_en[0] || o_pull_up[0] == $past(out_reg[0][0])))
    else $error("Pull active on a driven pin or pull direction wrong.");
  AST_INPUT_BUFFER_ENABLE_HOLD: assert property (
    !cfg_reg[0][0][`IPG_CFG_INPUT_BUFFER_ENABLE] |=> $stable(sif.q[0]))
    else $error("Input value sampled while input buffer disabled.");
  AST_DEMAND: assert property (
    i_pb_rd && !pb_grp && pb_dec.tgt == IPG_TGT_IN |=> demand_reg[0] == 2'h2 ##1 |demand_reg[0])
    else $error("On-demand sampling window not two cycles.");
  AST_ALIAS_READ: assert property (
    i_pb_rd && !pb_grp && pb_dec.tgt == IPG_TGT_OUT |=> o_pb_rdata == $past(out_reg[0]))
    else $error("Output alias read does not return the output register.");
  AST_ANALOG: assert property (
    cfg_reg[0][5][`IPG_CFG_PERIPH_MUX_ENABLE] && fsel_reg[0][5] == `IPG_FUNC_ANALOG
    |=> !o_pad_oe[5] && !o_pull_en[5] && !o_in_buf_en[5])
    else $error("Analog function left digital pad features on.");

  COV_BOTH_WRITE: cover property (pb_wen && lb_wen);
  COV_DEMAND_READ: cover property (i_pb_rd && pb_dec.tgt == IPG_TGT_IN ##1 demand_reg != '0);
  COV_PERIPH_DRIVE: cover property (cfg_reg[0][5][`IPG_CFG_PERIPH_MUX_ENABLE] ##1 o_pad_oe[5]);
endmodule : ipg_pin_group_ctrl

`default_nettype wire

// *** ipg_defs.svh ***
// Constants of the pin group controller: offsets, fields, reset values and counts.
// Assumes it is included once per file by its bare name.
`ifndef IPG_DEFS_SVH
`define IPG_DEFS_SVH

`define IPG_GROUPS          2
`define IPG_PINS            32
`define IPG_ALL_PINS        64
`define IPG_FUNCS           16
`define IPG_AW              8
`define IPG_GRP_BIT         7

`define IPG_OFS_DIR         7'h00
`define IPG_OFS_PIN_DIRECTION_CLEAR_A    7'h04
`define IPG_OFS_PIN_DIRECTION_SET_A    7'h08
`define IPG_OFS_PIN_DIRECTION_TOGGLE_A    7'h0C
`define IPG_OFS_OUT         7'h10
`define IPG_OFS_OUTPUT_LEVEL_CLEAR_A    7'h14
`define IPG_OFS_OUTPUT_LEVEL_SET_A    7'h18
`define IPG_OFS_OUTPUT_LEVEL_TOGGLE_A    7'h1C
`define IPG_OFS_IN          7'h20
`define IPG_OFS_CTRL        7'h24
`define IPG_OFS_PMUX        7'h30
`define IPG_OFS_PMUX_END    7'h40
`define IPG_OFS_PINCFG      7'h40
`define IPG_OFS_PINCFG_END  7'h60

`define IPG_CFG_PERIPH_MUX_ENABLE      0
`define IPG_CFG_INPUT_BUFFER_ENABLE        1
`define IPG_CFG_PULL_RESISTOR_ENABLE      2

`define IPG_RST_WORD        32'h0000_0000
`define IPG_RST_CFG         3'h0
`define IPG_RST_FSEL        4'h0
`define IPG_FUNC_ANALOG     4'h1
`define IPG_DEMAND_CYCLES   2'h2

`endif

// *** ipg_pkg.sv ***
// Types shared by the pin group controller and its synchroniser.
// Assumes ipg_defs.svh is on the include path.
`default_nettype none

package ipg_pkg;
  typedef enum logic [2:0] {
    IPG_TGT_NONE, IPG_TGT_DIR, IPG_TGT_OUT, IPG_TGT_IN,
    IPG_TGT_CTRL, IPG_TGT_PMUX, IPG_TGT_PINCFG
  } ipg_tgt_type;

  typedef enum logic [1:0] {
    IPG_OP_WRITE  = 2'h0,
    IPG_OP_CLEAR  = 2'h1,
    IPG_OP_SET    = 2'h2,
    IPG_OP_TOGGLE = 2'h3
  } ipg_op_type;

  typedef struct packed {
    ipg_tgt_type tgt;
    ipg_op_type  op;
    logic [2:0]  word;
  } ipg_dec_type;
endpackage : ipg_pkg

`default_nettype wire

// *** ipg_sync_if.sv ***
// Carries raw pad levels, per-pin sample enables and synchronised levels.
// Assumes the controller drives pad and enable and the synchroniser returns q.
`default_nettype none
`include "ipg_defs.svh"

interface ipg_sync_if;
  logic [`IPG_ALL_PINS-1:0] pad;
  logic [`IPG_ALL_PINS-1:0] en;
  logic [`IPG_ALL_PINS-1:0] q;
  modport ctrl (output pad, output en, input q);
  modport sync (input pad, input en, output q);
endinterface : ipg_sync_if

`default_nettype wire

// *** ipg_pin_sync.sv ***
// Two-stage pad synchroniser whose stages advance only while enabled.
// Assumes pads are asynchronous to i_ref_clk.
`default_nettype none
`include "ipg_defs.svh"

module ipg_pin_sync
  import ipg_pkg::*;
(
  input  wire logic    i_ref_clk, // port clock
  input  wire logic    i_rst_b,   // asynchronous reset, active low
  ipg_sync_if.sync     sif        // pads in, enables in, levels out
);
  logic [`IPG_ALL_PINS-1:0] meta_reg;
  logic [`IPG_ALL_PINS-1:0] meta_next;
  logic [`IPG_ALL_PINS-1:0] hold_reg;
  logic [`IPG_ALL_PINS-1:0] hold_next;

  // Gating both stages with one enable saves the toggling power of idle pins.
  for (genvar i = 0; i < `IPG_ALL_PINS; i++)
  begin : g_bit
    assign meta_next[i] = sif.en[i] ? sif.pad[i] : meta_reg[i];
    assign hold_next[i] = sif.en[i] ? meta_reg[i] : hold_reg[i];
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      meta_reg <= '0;
      hold_reg <= '0;
    end
    else
    begin
      meta_reg <= meta_next;
      hold_reg <= hold_next;
    end
  end

  assign sif.q = hold_reg;
endmodule : ipg_pin_sync

`default_nettype wire

// *** ipg_pad_model.sv ***
// Pad model: resolves every pad from the controller, an external driver and the pull.
// Assumes the testbench drives the external driver and shares the port clock.
`default_nettype none
`include "ipg_defs.svh"

module ipg_pad_model
(
  input  wire logic                     i_ref_clk,              // port clock
  input  wire logic [`IPG_ALL_PINS-1:0] i_out,                  // controller pad level
  input  wire logic [`IPG_ALL_PINS-1:0] i_oe,                   // controller driver enable
  input  wire logic [`IPG_ALL_PINS-1:0] i_pull_en,              // pull resistor enable
  input  wire logic [`IPG_ALL_PINS-1:0] i_pull_up,              // pull direction
  input  wire logic [`IPG_ALL_PINS-1:0] i_ext_en,               // external driver enable
  input  wire logic [`IPG_ALL_PINS-1:0] i_ext_lvl,              // external driver level
  output logic [`IPG_ALL_PINS-1:0]      o_pad                   // resolved pad level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic flt_reg = 1'b0;
  // A floating pad flips every cycle, so a stale level never passes for a real one.
  always @(posedge i_ref_clk)
    flt_reg <= ~flt_reg;
  always_comb
    for (int i = 0; i < `IPG_ALL_PINS; i++)
      o_pad[i] = i_oe[i] ? i_out[i] : i_ext_en[i] ? i_ext_lvl[i]
               : i_pull_en[i] ? i_pull_up[i] : flt_reg ^ i[0];
endmodule : ipg_pad_model

`default_nettype wire

// *** ipg_pin_group_ctrl_tb.sv ***
// Testbench of the pin group controller: register tasks on both buses and pad checks.
// Assumes ipg_defs.svh on the include path and the pad model compiled before it.
`default_nettype none
`include "ipg_defs.svh"

module ipg_pin_group_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam bit PB = 1'b0;
  localparam bit LB = 1'b1;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  pb_addr = 8'h00, lb_addr = 8'h00;
  logic [31:0] pb_wdata = 32'h0, lb_wdata = 32'h0, pb_rdata, lb_rdata;
  logic [3:0]  pb_be = 4'h0, lb_be = 4'h0;
  logic        pb_wr = 1'b0, pb_rd = 1'b0, lb_wr = 1'b0, lb_rd = 1'b0, pb_dbg = 1'b0;
  logic [1:0]  wr_prot = 2'h0;
  logic [63:0] pad, pad_out, pad_oe, pull_en, pull_up, in_buf_en, per_in;
  logic [63:0] ext_en = 64'h0, ext_lvl = 64'h0;
  logic [`IPG_FUNCS-1:0][63:0] drv = {`IPG_FUNCS{64'h0}}, poe = {`IPG_FUNCS{64'h0}};
  int          err_count = 0, total_checks = 0;

  always #2 clk = ~clk;

  ipg_pin_group_ctrl dut (.i_ref_clk(clk), .i_rst_b(rst_b), .i_pb_addr(pb_addr),
    .i_pb_wdata(pb_wdata), .i_pb_be(pb_be), .i_pb_wr(pb_wr), .i_pb_rd(pb_rd),
    .i_pb_debug(pb_dbg), .o_pb_rdata(pb_rdata), .i_lb_addr(lb_addr), .i_lb_wdata(lb_wdata),
    .i_lb_be(lb_be), .i_lb_wr(lb_wr), .i_lb_rd(lb_rd), .o_lb_rdata(lb_rdata),
    .i_wr_protect(wr_prot), .i_pad_in(pad), .o_pad_out(pad_out), .o_pad_oe(pad_oe),
    .o_pull_en(pull_en), .o_pull_up(pull_up), .o_in_buf_en(in_buf_en),
    .i_periph_drive(drv), .i_periph_oe(poe), .o_periph_pad_in(per_in));

  ipg_pad_model pads (.i_ref_clk(clk), .i_out(pad_out),
    .i_oe(pad_oe), .i_pull_en(pull_en), .i_pull_up(pull_up), .i_ext_en(ext_en),
    .i_ext_lvl(ext_lvl), .o_pad(pad));

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Address and data go to both buses; only the strobe of the chosen bus rises.
  task automatic acc(input bit lb, input bit w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    @(posedge clk);
    {pb_addr, pb_wdata, pb_be, lb_addr, lb_wdata, lb_be} <= {a, d, be, a, d, be};
    {pb_wr, pb_rd, lb_wr, lb_rd} <= {!lb & w, !lb & !w, lb & w, lb & !w};
    @(posedge clk);
    {pb_wr, pb_rd, lb_wr, lb_rd} <= 4'h0;
  endtask : acc

  task automatic wr(input bit lb, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] be);
    acc(lb, 1'b1, a, d, be);
  endtask : wr

  task automatic rd(input bit lb, input logic [7:0] a, input logic [31:0] exp);
    acc(lb, 1'b0, a, 32'h0, 4'hF);
    #1;
    chk(lb ? lb_rdata : pb_rdata, {32'h0, exp});
  endtask : rd

  // Pads follow the registers one edge after the write lands.
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  initial
  begin
    #100000;
    err_count++;
    report_and_stop();
  end

  initial
  begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    chk(pad_out | pad_oe | pull_en | pull_up | in_buf_en | per_in, 64'h0);
    rd(PB, 8'h00, 32'h0);
    wr(PB, 8'h00, 32'hF0, 4'hF);
    wr(PB, 8'h08, 32'h01, 4'hF);
    wr(PB, 8'h04, 32'h10, 4'hF);
    wr(PB, 8'h0C, 32'h03, 4'hF);
    rd(PB, 8'h0C, 32'hE2);
    wr(PB, 8'h10, 32'hFFFF_FFFF, 4'h2);
    wr(PB, 8'h18, 32'h02, 4'hF);
    wr(PB, 8'h14, 32'hF000, 4'hF);
    wr(PB, 8'h1C, 32'h24, 4'hF);
    rd(PB, 8'h10, 32'h0F26);
    settle();
    chk(pad_oe, 64'hE2);
    chk(pad_out & pad_oe, 64'h22);
    wr(PB, 8'h48, 32'h0406, 4'h3);
    settle();
    chk(pull_en, 64'h300);
    chk(pull_up & pull_en, 64'h300);
    chk(in_buf_en, 64'h100);
    wr(PB, 8'h40, 32'h0200, 4'h2);
    wr(PB, 8'h24, 32'h0302, 4'hF);
    repeat (6) @(posedge clk);
    rd(PB, 8'h20, 32'h0102);
    ext_en[12] <= 1'b1;
    ext_lvl[12] <= 1'b1;
    wr(PB, 8'h4C, 32'h02, 4'h1);
    repeat (6) @(posedge clk);
    rd(PB, 8'h20, 32'h0102);
    repeat (3) @(posedge clk);
    rd(PB, 8'h20, 32'h1102);
    rd(LB, 8'h20, 32'h1102);
    wr(LB, 8'h08, 32'h0100, 4'h2);
    wr(LB, 8'h24, 32'h0, 4'hF);
    rd(LB, 8'h00, 32'h01E2);
    rd(PB, 8'h24, 32'h0302);
    rd(LB, 8'h48, 32'h0);
    settle();
    chk(pull_en, 64'h200);
    @(posedge clk);
    {pb_addr, pb_wdata, pb_be, pb_wr} <= {8'h10, 32'h0, 4'hF, 1'b1};
    {lb_addr, lb_wdata, lb_be, lb_wr} <= {8'h18, 32'h8, 4'hF, 1'b1};
    @(posedge clk);
    {pb_wr, lb_wr} <= 2'h0;
    rd(PB, 8'h10, 32'h8);
    rd(PB, 8'h28, 32'h0);
    @(posedge clk);
    wr_prot <= 2'h1;
    wr(PB, 8'h08, 32'h2000_0000, 4'h8);
    pb_dbg <= 1'b1;
    wr(PB, 8'h0C, 32'h4000_0000, 4'h8);
    wr_prot <= 2'h0;
    pb_dbg <= 1'b0;
    rd(PB, 8'h00, 32'h4000_01E2);
    wr(PB, 8'h88, 32'h1, 4'h1);
    rd(PB, 8'h80, 32'h1);
    settle();
    chk(pad_oe, 64'h0000_0001_4000_01E2);
    @(posedge clk);
    drv[3][5] <= 1'b1;
    poe[3][5] <= 1'b1;
    poe[1][5] <= 1'b1;
    wr(PB, 8'h44, 32'h0300, 4'h2);
    wr(PB, 8'h30, 32'h0030_0000, 4'h4);
    repeat (6) @(posedge clk);
    #1;
    chk({pad_out[5], pad_oe[5], per_in[5]}, 64'h7);
    wr(PB, 8'h30, 32'h0010_0000, 4'h4);
    settle();
    chk({pad_oe[5], pull_en[5], in_buf_en[5]}, 64'h0);
    report_and_stop();
  end
endmodule : ipg_pin_group_ctrl_tb

`default_nettype wire
